// >>> led_prog_top.sv
// one wire pulse count programmer and control for a six channel led driver
`timescale 1ns/1ps
`include "led_prog_params.svh"

module led_prog_top #(
	parameter int ADDR_GAP = `ADDR_GAP_CYC,
	parameter int OFF_DELAY = `OFF_DELAY_CYC,
	parameter int MODE_DELAY = `MODE_DELAY_CYC,
	parameter int POR_DELAY = `POR_DELAY_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic prog_line,
	input wire logic undervoltage,
	input wire logic [5:0] headroom_low,
	input wire logic [5:0] cathode_near_out,
	input wire logic [5:0] cathode_released,
	output led_prog_pkg::current_t current_a1,
	output led_prog_pkg::current_t current_a2,
	output led_prog_pkg::current_t current_b1,
	output led_prog_pkg::current_t current_b2,
	output led_prog_pkg::current_t current_c1,
	output led_prog_pkg::current_t current_c2,
	output logic [5:0] led_channel_output_oe,
	output logic [5:0] sense_current_on,
	output logic device_enabled,
	output led_prog_pkg::pump_mode_e pump_mode
);
	import led_prog_pkg::*;

	// ****************************************
	// line synchroniser and glitch filter
	// ****************************************
	logic line_meta_r;
	logic line_sync_r;
	logic line_filt_r;
	logic line_prev_r;
	logic [3:0] glitch_cnt_r;
	logic uv_meta1_r;
	logic uv_sync_r;
	logic [5:0] hr_meta_r;
	logic [5:0] hr_sync_r;
	logic [5:0] near_meta_r;
	logic [5:0] near_sync_r;
	logic [5:0] rel_meta_r;
	logic [5:0] rel_sync_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			line_meta_r <= 1'b0;
			line_sync_r <= 1'b0;
		end else begin
			line_meta_r <= prog_line;
			line_sync_r <= line_meta_r;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			uv_meta1_r <= 1'b0;
			uv_sync_r <= 1'b0;
			hr_meta_r <= '0;
			hr_sync_r <= '0;
			near_meta_r <= '0;
			near_sync_r <= '0;
			rel_meta_r <= '0;
			rel_sync_r <= '0;
		end else begin
			uv_meta1_r <= undervoltage;
			uv_sync_r <= uv_meta1_r;
			hr_meta_r <= headroom_low;
			hr_sync_r <= hr_meta_r;
			near_meta_r <= cathode_near_out;
			near_sync_r <= near_meta_r;
			rel_meta_r <= cathode_released;
			rel_sync_r <= rel_meta_r;
		end
	end

	// level must differ for the full minimum width before it is accepted
	always_ff @(posedge clk) begin
		if (reset) begin
			line_filt_r <= 1'b0;
			glitch_cnt_r <= '0;
		end else if (line_sync_r == line_filt_r) begin
			glitch_cnt_r <= '0;
		end else if (glitch_cnt_r == 4'(`MIN_PULSE_CYC - 1)) begin
			line_filt_r <= line_sync_r;
			glitch_cnt_r <= '0;
		end else begin
			glitch_cnt_r <= glitch_cnt_r + 4'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			line_prev_r <= 1'b0;
		else
			line_prev_r <= line_filt_r;
	end

	logic fall;
	logic rise;
	assign fall = line_prev_r && !line_filt_r;
	assign rise = !line_prev_r && line_filt_r;

	// ****************************************
	// power-on settle, phase timers
	// ****************************************
	logic [8:0] por_cnt_r;
	logic por_done_r;
	logic [15:0] high_cnt_r;
	logic [15:0] low_cnt_r;
	logic gap_seen;
	logic off_seen;

	always_ff @(posedge clk) begin
		if (reset) begin
			por_cnt_r <= '0;
			por_done_r <= 1'b0;
		end else if (!por_done_r) begin
			if (por_cnt_r == 9'(POR_DELAY - 1))
				por_done_r <= 1'b1;
			else
				por_cnt_r <= por_cnt_r + 9'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !line_filt_r)
			high_cnt_r <= '0;
		else if (!gap_seen)
			high_cnt_r <= high_cnt_r + 16'd1;
	end

	always_ff @(posedge clk) begin
		if (reset || line_filt_r)
			low_cnt_r <= '0;
		else if (!off_seen)
			low_cnt_r <= low_cnt_r + 16'd1;
	end

	assign gap_seen = high_cnt_r >= 16'(ADDR_GAP);
	assign off_seen = low_cnt_r >= 16'(OFF_DELAY);

	// ****************************************
	// address and data burst decoder
	// ****************************************
	link_state_e state_r;
	logic [6:0] pulse_cnt_r;
	logic [2:0] sel_r;
	logic sel_pending_r;
	logic shutdown;

	// low count clears a cycle late; gate it so a rise can re-enable
	assign shutdown = (off_seen && !line_filt_r) || uv_sync_r;

	logic [3:0] bank_enable_and_range_r;
	code_t global_current_code_r;
	code_t bank_c_current_code_r;
	code_t bank_b_current_code_r;
	code_t bank_a_current_code_r;
	logic pump_mode_restart_r;
	logic burst_end;
	logic pump_restart_pulse;

	assign burst_end = gap_seen && pulse_cnt_r != '0;

	always_ff @(posedge clk) begin
		if (reset || shutdown) begin
			state_r <= LINK_OFF;
			pulse_cnt_r <= '0;
			sel_r <= '0;
			sel_pending_r <= 1'b0;
		end else begin
			unique case (state_r)
				LINK_OFF: begin
					if (rise && por_done_r)
						state_r <= LINK_ADDR;
				end
				LINK_ADDR: begin
					if (fall && pulse_cnt_r != 7'h7f)
						pulse_cnt_r <= pulse_cnt_r + 7'd1;
					else if (burst_end) begin
						pulse_cnt_r <= '0;
						if (pulse_cnt_r <= 7'(`REG_COUNT)) begin
							sel_r <= pulse_cnt_r[2:0];
							sel_pending_r <= 1'b1;
							state_r <= LINK_DATA;
						end
					end
				end
				LINK_DATA: begin
					if (fall && pulse_cnt_r != 7'h7f)
						pulse_cnt_r <= pulse_cnt_r + 7'd1;
					else if (burst_end) begin
						pulse_cnt_r <= '0;
						sel_pending_r <= 1'b0;
						state_r <= LINK_IDLE;
					end
				end
				LINK_IDLE: begin
					if (fall) begin
						pulse_cnt_r <= 7'd1;
						state_r <= LINK_ADDR;
					end
				end
			endcase
		end
	end
	// a selected register with no data keeps LINK_DATA waiting

	logic sel_now;
	logic write_now;
	assign sel_now = state_r == LINK_ADDR && !fall && burst_end
		&& pulse_cnt_r <= 7'(`REG_COUNT);
	assign write_now = state_r == LINK_DATA && !fall && burst_end;

	// data code is range minus pulse count, modulo the range
	code_t data_code;
	logic [3:0] data_code4;
	assign data_code = 6'(7'd64 - pulse_cnt_r);
	assign data_code4 = 4'(5'd16 - 5'(pulse_cnt_r));

	// ****************************************
	// programmable registers
	// ****************************************
	function automatic code_t next_code(input code_t cur,
			input logic [2:0] idx);
		code_t r;
		r = cur;
		if (sel_now && pulse_cnt_r[2:0] == idx)
			r = '0;
		else if (write_now && sel_r == idx)
			r = data_code;
		return r;
	endfunction

	always_ff @(posedge clk) begin
		if (reset || shutdown) begin
			bank_enable_and_range_r <= '0;
			global_current_code_r <= '0;
			bank_c_current_code_r <= '0;
			bank_b_current_code_r <= '0;
			bank_a_current_code_r <= '0;
			pump_mode_restart_r <= 1'b0;
		end else begin
			if (sel_now && pulse_cnt_r[2:0] == `REG_BANK_ENABLE)
				bank_enable_and_range_r <= '0;
			else if (write_now && sel_r == `REG_BANK_ENABLE)
				bank_enable_and_range_r <= data_code4;
			global_current_code_r <= next_code(global_current_code_r,
				`REG_GLOBAL_CODE);
			bank_c_current_code_r <= next_code(bank_c_current_code_r,
				`REG_BANK_C_CODE);
			bank_b_current_code_r <= next_code(bank_b_current_code_r,
				`REG_BANK_B_CODE);
			bank_a_current_code_r <= next_code(bank_a_current_code_r,
				`REG_BANK_A_CODE);
			// trigger register: bit 0 set restarts the pump, then clears
			pump_mode_restart_r <= write_now
				&& sel_r == `REG_PUMP_RESTART && data_code[0];
		end
	end

	assign pump_restart_pulse = pump_mode_restart_r;

	// ****************************************
	// pump ratio control
	// ****************************************
	logic [5:0] active_mask;
	logic pump_run;
	pump_mode_e mode_w;

	assign pump_run = state_r != LINK_OFF;

	pump_mode_ctrl #(
		.MODE_DELAY(MODE_DELAY)
	) u_pump (
		.clk(clk),
		.reset(reset),
		.run(pump_run),
		.restart(pump_restart_pulse),
		.headroom_low(|(hr_sync_r & active_mask)),
		.mode(mode_w)
	);

	// ****************************************
	// channel current outputs
	// ****************************************
	logic [5:0] shorted_r;
	logic [2:0] bank_on;
	current_t chan_cur [6];

	assign bank_on = bank_enable_and_range_r[2:0];
	assign active_mask = {{2{bank_on[2]}}, {2{bank_on[1]}},
		{2{bank_on[0]}}} & ~shorted_r;

	// each bank code is ORed with the global code, so an empty bank code gives the global code
	function automatic current_t scale(input code_t c, input logic on);
		current_t v;
		v = '0;
		// step is eight times the low-range unit: code+1 in high range
		if (on && bank_enable_and_range_r[`RANGE_SEL_BIT])
			v = {current_t'(c) + 9'd1} << `RANGE_SHIFT;
		else if (on)
			v = current_t'(c);
		return v;
	endfunction

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_chan
			code_t code_sel;
			assign code_sel = (g < 2 ? bank_a_current_code_r :
				g < 4 ? bank_b_current_code_r : bank_c_current_code_r)
				| global_current_code_r;
			always_ff @(posedge clk) begin
				if (reset || shutdown) begin
					shorted_r[g] <= 1'b0;
				end else if (near_sync_r[g] && bank_on[g / 2]) begin
					shorted_r[g] <= 1'b1;
				end else if (rel_sync_r[g]) begin
					shorted_r[g] <= 1'b0;
				end
			end
			assign chan_cur[g] = scale(code_sel,
				bank_on[g / 2] && !shorted_r[g]);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset || shutdown || state_r == LINK_OFF) begin
			current_a1 <= '0;
			current_a2 <= '0;
			current_b1 <= '0;
			current_b2 <= '0;
			current_c1 <= '0;
			current_c2 <= '0;
			led_channel_output_oe <= '0;
			sense_current_on <= '0;
			device_enabled <= 1'b0;
			pump_mode <= PUMP_1X;
		end else begin
			current_a1 <= chan_cur[0];
			current_a2 <= chan_cur[1];
			current_b1 <= chan_cur[2];
			current_b2 <= chan_cur[3];
			current_c1 <= chan_cur[4];
			current_c2 <= chan_cur[5];
			led_channel_output_oe <= active_mask;
			sense_current_on <= shorted_r;
			device_enabled <= 1'b1;
			pump_mode <= mode_w;
		end
	end
endmodule

// >>> led_prog_params.svh
// timing counts, register indices and field positions for the led programmer
`ifndef LED_PROG_PARAMS_SVH
`define LED_PROG_PARAMS_SVH

`define CLK_FREQ_HZ 25000000
`define CLK_PERIOD_NS 40
`define MIN_PULSE_NS 200
`define MIN_PULSE_CYC ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_GAP_US 500
`define ADDR_GAP_CYC (`ADDR_GAP_US * 1000 / `CLK_PERIOD_NS)
`define OFF_DELAY_US 1000
`define OFF_DELAY_CYC (`OFF_DELAY_US * 1000 / `CLK_PERIOD_NS)
`define MODE_DELAY_US 800
`define MODE_DELAY_CYC (`MODE_DELAY_US * 1000 / `CLK_PERIOD_NS)
`define POR_DELAY_US 10
`define POR_DELAY_CYC (`POR_DELAY_US * 1000 / `CLK_PERIOD_NS)

`define REG_BANK_ENABLE 3'd1
`define REG_GLOBAL_CODE 3'd2
`define REG_BANK_C_CODE 3'd3
`define REG_BANK_B_CODE 3'd4
`define REG_BANK_A_CODE 3'd5
`define REG_PUMP_RESTART 3'd6
`define REG_COUNT 6

`define BANK_A_ON_BIT 0
`define BANK_B_ON_BIT 1
`define BANK_C_ON_BIT 2
`define RANGE_SEL_BIT 3
`define RANGE_SHIFT 3

`endif

// >>> led_prog_pkg.sv
// types shared by the led programmer
package led_prog_pkg;
	typedef enum logic [1:0] {
		PUMP_1X = 2'b00,
		PUMP_1X5 = 2'b01,
		PUMP_2X = 2'b10
	} pump_mode_e;
	typedef enum logic [1:0] {
		LINK_OFF = 2'b00,
		LINK_ADDR = 2'b01,
		LINK_DATA = 2'b10,
		LINK_IDLE = 2'b11
	} link_state_e;
	typedef logic [5:0] code_t;
	typedef logic [8:0] current_t;
endpackage

// >>> pump_mode_ctrl.sv
// charge pump ratio stepper
`timescale 1ns/1ps
`include "led_prog_params.svh"
module pump_mode_ctrl #(
	parameter int MODE_DELAY = `MODE_DELAY_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic run,
	input wire logic restart,
	input wire logic headroom_low,
	output led_prog_pkg::pump_mode_e mode
);
	import led_prog_pkg::*;

	logic [19:0] wait_r;

	always_ff @(posedge clk) begin
		if (reset || !run || restart) begin
			mode <= PUMP_1X;
			wait_r <= '0;
		end else if (headroom_low && mode != PUMP_2X) begin
			if (wait_r == 20'(MODE_DELAY - 1)) begin
				wait_r <= '0;
				// step to next ratio; holds at 2x
				mode <= (mode == PUMP_1X) ? PUMP_1X5 : PUMP_2X;
			end else begin
				wait_r <= wait_r + 20'd1;
			end
		end else begin
			wait_r <= '0;
		end
	end
endmodule

// >>> led_prog_sva.sv
// assertions on the ports of the led programmer top
`timescale 1ns/1ps
module led_prog_sva #(
	parameter int OFF_DELAY = 100,
	parameter int MODE_DELAY = 40
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic prog_line,
	input wire logic undervoltage,
	input wire logic [5:0] headroom_low,
	input wire logic [5:0] cathode_near_out,
	input led_prog_pkg::current_t current_a1,
	input led_prog_pkg::current_t current_c1,
	input logic [5:0] led_channel_output_oe,
	input logic [5:0] sense_current_on,
	input logic device_enabled,
	input led_prog_pkg::pump_mode_e pump_mode
);
	import led_prog_pkg::*;
	int low_cnt;
	int hr_cnt;
	logic uv_seen;
	// ****************
	// helper counters
	// ****************
	always_ff @(posedge clk) begin
		if (reset || prog_line)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	always_ff @(posedge clk) begin
		if (reset || headroom_low == 6'h00)
			hr_cnt <= 0;
		else
			hr_cnt <= hr_cnt + 1;
	end
	// sticky: a supply drop may end a run without a long low
	always_ff @(posedge clk) begin
		if (reset)
			uv_seen <= 1'b0;
		else if (undervoltage)
			uv_seen <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	oe_off_a: assert property (!device_enabled |->
		led_channel_output_oe == 0)
		else $error("channel driven in shutdown");
	zero_off_a: assert property (!device_enabled |-> current_a1 == 0)
		else $error("current left on in shutdown");
	enable_zero_a: assert property ($rose(device_enabled) |->
		current_a1 == 0 && current_c1 == 0 && pump_mode == PUMP_1X)
		else $error("enable without zero current or 1x");
	uv_off_a: assert property (undervoltage |-> ##[1:8] !device_enabled)
		else $error("undervoltage kept device on");
	pump_order_a: assert property ($changed(pump_mode) &&
		pump_mode != PUMP_1X |-> pump_mode != 2'b11 &&
		$past(pump_mode) == pump_mode - 2'b01)
		else $error("pump step out of order");
	pump_wait_a: assert property ($changed(pump_mode) &&
		pump_mode != PUMP_1X |-> hr_cnt >= MODE_DELAY)
		else $error("pump stepped too early");
	off_slow_a: assert property ($fell(device_enabled) && !uv_seen |->
		low_cnt >= OFF_DELAY)
		else $error("power down too early");
	off_fast_a: assert property (low_cnt == OFF_DELAY + 12 |->
		!device_enabled)
		else $error("power down too late");
	sense_excl_a: assert property ((sense_current_on &
		led_channel_output_oe) == 6'h00)
		else $error("sensed channel still driven");
	near_sense_a: assert property (cathode_near_out[0] &&
		led_channel_output_oe[0] |-> ##[1:8] sense_current_on[0])
		else $error("near cathode not sensed");
endmodule
bind led_prog_top led_prog_sva #(.OFF_DELAY(OFF_DELAY),
	.MODE_DELAY(MODE_DELAY)) i_sva (.clk(clk), .reset(reset),
	.prog_line(prog_line), .undervoltage(undervoltage),
	.headroom_low(headroom_low), .cathode_near_out(cathode_near_out),
	.current_a1(current_a1), .current_c1(current_c1),
	.led_channel_output_oe(led_channel_output_oe),
	.sense_current_on(sense_current_on),
	.device_enabled(device_enabled), .pump_mode(pump_mode));

// >>> host_model.sv
// host driving the one wire enable and programming line
`timescale 1ns/1ps
module host_model #(
	parameter int GAP = 210
) (
	input wire logic clk,
	output logic prog_line
);
	// ****************
	// line driver
	// ****************
	initial prog_line = 1'b0;
	// gap covers address-to-data, data-to-address and retry waits
	task automatic burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) prog_line <= 1'b0;
			repeat (8) @(posedge clk);
			prog_line <= 1'b1;
			repeat (7) @(posedge clk);
		end
		repeat (GAP) @(posedge clk);
	endtask
	task automatic write(input int a, input int n);
		burst(a);
		burst(n);
	endtask
	task automatic glitch();
		@(posedge clk) prog_line <= 1'b0;
		@(posedge clk) prog_line <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	task automatic level(input logic v, input int cyc);
		@(posedge clk) prog_line <= v;
		repeat (cyc) @(posedge clk);
	endtask
endmodule

// >>> tb_top.sv
// self-checking bench for the led programmer
`timescale 1ns/1ps
module tb_top;
	import led_prog_pkg::*;
	localparam int AG = 50;
	localparam int OD = 100;
	localparam int MD = 40;
	localparam int PD = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic prog_line;
	logic undervoltage = 1'b0;
	logic [5:0] headroom_low = 6'h00;
	logic [5:0] cathode_near_out = 6'h00;
	logic [5:0] cathode_released = 6'h00;
	current_t a1, a2, b1, b2, c1, c2;
	logic [5:0] oe, sense;
	logic en;
	pump_mode_e pm;
	int num_errors = 0;
	int total_checks = 0;
	always #20 clk = ~clk;
	host_model #(.GAP(4 * AG + 10)) i_host (.clk(clk), .prog_line(prog_line));
	led_prog_top #(.ADDR_GAP(AG), .OFF_DELAY(OD), .MODE_DELAY(MD),
		.POR_DELAY(PD)) i_dut (.clk(clk), .reset(reset),
		.prog_line(prog_line), .undervoltage(undervoltage),
		.headroom_low(headroom_low), .cathode_near_out(cathode_near_out),
		.cathode_released(cathode_released), .current_a1(a1),
		.current_a2(a2), .current_b1(b1), .current_b2(b2),
		.current_c1(c1), .current_c2(c2), .led_channel_output_oe(oe),
		.sense_current_on(sense), .device_enabled(en), .pump_mode(pm));
	// ****************
	// shared helpers
	// ****************
	function automatic current_t cur(input logic rng, input code_t c);
		return rng ? {c, 3'b000} + 9'h008 : {3'h0, c};
	endfunction
	task automatic chk(input string nm, input logic [8:0] e, logic [8:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_enable();
		i_host.level(1'b1, PD);
		cyc(1);
		chk("early rise", 9'h000, {8'h00, en});
		i_host.level(1'b0, PD);
		i_host.level(1'b1, 20);
		cyc(1);
		chk("enabled", 9'h001, {8'h00, en});
		chk("a1", 9'h000, a1);
		chk("pump", 9'h000, {7'h00, pm});
	endtask
	task automatic t_program();
		i_host.write(1, 3);
		i_host.write(5, 60);
		i_host.write(3, 62);
		cyc(1);
		chk("a1", cur(1'b1, 6'h04), a1);
		chk("a2", cur(1'b1, 6'h04), a2);
		chk("c2", cur(1'b1, 6'h02), c2);
		chk("b1", 9'h000, b1);
		chk("oe", 9'h033, {3'h0, oe});
		i_host.write(1, 11);
		cyc(1);
		chk("a1 low", cur(1'b0, 6'h04), a1);
		i_host.burst(7);
		cyc(1);
		chk("a1 kept", cur(1'b0, 6'h04), a1);
	endtask
	task automatic t_select();
		i_host.glitch();
		i_host.burst(5);
		cyc(1);
		chk("a1 clr", 9'h000, a1);
		i_host.burst(61);
		cyc(1);
		chk("a1 data", cur(1'b0, 6'h03), a1);
	endtask
	task automatic t_pump();
		@(posedge clk) headroom_low <= 6'h01;
		cyc(MD + 20);
		chk("pump", 9'h001, {7'h00, pm});
		cyc(MD + 20);
		chk("pump", 9'h002, {7'h00, pm});
		cyc(MD + 20);
		chk("pump", 9'h002, {7'h00, pm});
		@(posedge clk) headroom_low <= 6'h00;
		i_host.write(6, 1);
		cyc(1);
		chk("pump", 9'h000, {7'h00, pm});
	endtask
	task automatic t_sense();
		@(posedge clk) cathode_near_out <= 6'h01;
		cyc(10);
		chk("sense", 9'h001, {8'h00, sense[0]});
		chk("oe0", 9'h000, {8'h00, oe[0]});
		@(posedge clk) cathode_near_out <= 6'h00;
		cathode_released <= 6'h01;
		cyc(10);
		chk("oe0", 9'h001, {8'h00, oe[0]});
		@(posedge clk) cathode_released <= 6'h00;
	endtask
	task automatic t_off();
		i_host.level(1'b0, OD + 20);
		cyc(1);
		chk("enabled", 9'h000, {8'h00, en});
		chk("oe", 9'h000, {3'h0, oe});
		i_host.level(1'b1, 20);
		cyc(1);
		chk("a1", 9'h000, a1);
		i_host.write(1, 1);
		i_host.write(2, 60);
		cyc(1);
		chk("b1 glob", cur(1'b1, 6'h04), b1);
		chk("c1 glob", cur(1'b1, 6'h04), c1);
		chk("b2 glob", cur(1'b1, 6'h04), b2);
		@(posedge clk) undervoltage <= 1'b1;
		cyc(10);
		chk("enabled", 9'h000, {8'h00, en});
		chk("oe", 9'h000, {3'h0, oe});
		@(posedge clk) undervoltage <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_enable();
		t_program();
		t_select();
		t_pump();
		t_sense();
		t_off();
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
endmodule
